// >>> cmb_node.sv
// Purpose: stand-in for the protocol engine and the other nodes on the bus
// Assumes: every task is entered just after a rising edge of pclk
// Notes:   idle data lines show the inverse of the last byte, never a held value
`timescale 1ns/1ps
`default_nettype none
module cmb_node (
  input  wire logic                 pclk,  // engine clock
  output wire cmb_pkg::cmb_eng_in_t eng    // frame events to the store
);
  logic [4:0] evt;   // tick, pick, ok, fail, ack delimiter
  logic       we;
  logic [3:0] addr;
  logic [7:0] data;
  logic       ok;
  logic       pass;
  logic       own;
  logic [3:0] rd;    // byte of the active slot that the engine fetches

  assign eng = {evt, we, addr, data, ok, pass, own, rd};

  // quiet lines until the bench starts calling tasks
  initial begin
    evt  = 5'h00;
    we   = 1'b0;
    addr = 4'h0;
    data = 8'h00;
    ok   = 1'b0;
    pass = 1'b0;
    own  = 1'b0;
    rd   = 4'h0;
  end

  // fetch address, then two edges so the fetched byte has settled on return
  task automatic rd_at(input logic [3:0] a);
    rd <= a;
    repeat (2) @(posedge pclk);
  endtask

  // one pulse, then one quiet cycle so that calls may follow back to back
  task automatic ev(input logic [4:0] e);
    evt <= e;
    @(posedge pclk);
    evt <= 5'h00;
    @(posedge pclk);
  endtask

  task automatic ticks(input int n);
    evt <= 5'h10;
    repeat (n) @(posedge pclk);
    evt <= 5'h00;
    @(posedge pclk);
  endtask

  // 13 message bytes, ack delimiter, then the end of frame with the verdict
  task automatic rx_frame(input logic [7:0] b0, input logic p, input logic o);
    own <= o;
    for (int i = 0; i < 13; i++) begin
      we   <= 1'b1;
      addr <= 4'(i);
      data <= b0 + 8'(i);
      @(posedge pclk);
    end
    we   <= 1'b0;
    addr <= ~addr;
    data <= ~data;
    ev(5'h01);
    pass <= p;
    ok   <= 1'b1;
    @(posedge pclk);
    ok   <= 1'b0;
    pass <= ~p;
    own  <= 1'b0;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// >>> cmb_pkg.sv
// Purpose: constants and carrier types for the CAN message buffer store
// Assumes: 32-bit APB, registers of at most 16 bits in the low bits of each word
// Notes:   all offsets are byte addresses
`default_nettype none
package cmb_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned NUM_TX        = 3;
  localparam int unsigned NUM_RX        = 5;
  localparam int unsigned SLOT_BYTES    = 16;
  localparam int unsigned STAMP_W       = 16;
  // register map (byte addresses)
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_TX_FLAG   = 12'h004;
  localparam logic [11:0] OFF_IRQ_EN    = 12'h008;
  localparam logic [11:0] OFF_ABORT_RQ  = 12'h00c;
  localparam logic [11:0] OFF_ABORT_AK  = 12'h010;
  localparam logic [11:0] OFF_TX_SEL    = 12'h014;
  localparam logic [11:0] OFF_RX_FLAG   = 12'h018;
  localparam logic [11:0] OFF_STAMP_CNT = 12'h01c;
  localparam logic [11:0] OFF_RX_WIN    = 12'h040;
  localparam logic [11:0] OFF_TX_WIN    = 12'h080;
  // byte positions inside a slot window
  localparam logic [3:0]  POS_LOCAL_PRIORITY_FIELD      = 4'hd;
  localparam logic [3:0]  POS_STAMP_HI  = 4'he;
  localparam logic [3:0]  POS_STAMP_LO  = 4'hf;
  // control register fields
  localparam int unsigned CTRL_INIT     = 0;
  localparam int unsigned CTRL_STAMP    = 1;
  localparam int unsigned CTRL_LOOP     = 2;
  localparam logic [2:0]  CTRL_RST      = 3'h1;
  // interrupt enable fields: [2:0] tx slots, then rx, then overrun
  localparam int unsigned IEN_RX        = 3;
  localparam int unsigned IEN_OVR       = 4;
  localparam logic [4:0]  IEN_RST       = 5'h00;
  // receive flag register fields
  localparam int unsigned RXF_FULL      = 0;
  localparam int unsigned RXF_OVR       = 1;
  localparam logic [2:0]  TX_EMPTY_RST  = 3'h7;

  typedef struct packed {
    logic       bit_tick;    // one pulse per nominal bit time
    logic       tx_pick;     // prioritise just before start of frame
    logic       tx_ok;       // current frame sent and acknowledged
    logic       tx_fail;     // error or lost arbitration, retry later
    logic       ack_delim;   // sample point of the ack delimiter
    logic       rx_we;       // byte write into background slot
    logic [3:0] rx_addr;
    logic [7:0] rx_data;
    logic       rx_ok;       // frame ended without error
    logic       filter_pass; // acceptance filter verdict, valid with rx_ok
    logic       own_frame;   // frame on the bus is our own transmission
    logic [3:0] tx_rd_addr;  // byte of the active tx slot to fetch
  } cmb_eng_in_t;

  typedef struct packed {
    logic       tx_valid;    // a queued slot was picked
    logic [1:0] tx_idx;      // index of the picked slot
    logic [7:0] tx_rd_data;  // byte fetched, one cycle after tx_rd_addr
    logic       ack_allow;   // engine may drive the ack slot
  } cmb_eng_out_t;
endpackage
`default_nettype wire

// >>> cmb_store.sv
// Purpose: message buffers, tx scheduling, rx fifo and time stamping
// Assumes: protocol engine delivers bit ticks, frame events and rx bytes
// Notes:   apb slave with zero wait states; unmapped addresses give pslverr
// Operation
// - stamp active buffer when frame is acknowledged
// - capture at ack delimiter sample point
// - free-running bit counter, silent wrap
// - counter held zero in init mode
// - stamp bytes read-only, visible when selected empty
// - exactly three transmit slots
// - slot: 13 message bytes, priority, stamp
// - select register maps empty slot into window
// - clearing empty queues, sending sets again
// - tx interrupt on empty flag unless masked
// - lowest priority value wins, every attempt
// - ties go to lower slot index
// - priority accessible only when selected and empty
// - abort queued idle slot, acknowledge, release
// - abort flag tells aborted from sent
// - five-entry rx fifo, foreground visible only
// - rx slot holds 13 message bytes
// - accepted frame shifts in, flag, interrupt
// - back-to-back frames land in background slot
// - invalid frames never shift, get overwritten
// - own frames captured but queued only in loop mode
// - lost arbitration frames received normally
// - full fifo discards, overrun flagged
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cmb_store #(
  parameter int unsigned NUM_TX = cmb_pkg::NUM_TX,
  parameter int unsigned NUM_RX = cmb_pkg::NUM_RX
) (
  input  wire logic                  pclk,      // apb clock
  input  wire logic                  presetn,   // async reset, active low
  input  wire logic [11:0]           paddr,     // byte address
  input  wire logic                  psel,      // slave select
  input  wire logic                  penable,   // access phase
  input  wire logic                  pwrite,    // write when high
  input  wire logic [31:0]           pwdata,    // write data
  output logic      [31:0]           prdata,    // read data
  output logic                       pready,    // transfer done
  output logic                       pslverr,   // unmapped address
  input  wire cmb_pkg::cmb_eng_in_t  eng,       // protocol engine events
  output var cmb_pkg::cmb_eng_out_t  eng_out,   // answers to the engine
  output logic                       tx_irq,    // some enabled slot empty
  output logic                       rx_irq,    // foreground holds a frame
  output logic                       ovr_irq    // overrun pending
);
  // ---------------- storage ----------------
  logic [7:0] txb  [NUM_TX][cmb_pkg::SLOT_BYTES];
  logic [7:0] bg   [cmb_pkg::SLOT_BYTES];
  logic [7:0] fifo [NUM_RX][cmb_pkg::SLOT_BYTES];

  logic [2:0]  ctrl;
  logic [4:0]  ien;
  logic [2:0]  empty;
  logic [2:0]  abrq;
  logic [2:0]  abak;
  logic [2:0]  tsel;
  logic        ovr;
  logic [15:0] cnt;
  logic        busy;
  logic [1:0]  cur;
  logic [2:0]  wr_ptr;
  logic [2:0]  rd_ptr;
  logic [2:0]  count;

  function automatic logic [2:0] lowest_one(input logic [2:0] v);
    lowest_one = v[0] ? 3'h1 : v[1] ? 3'h2 : v[2] ? 3'h4 : 3'h0;
  endfunction

  function automatic logic [1:0] onehot_idx(input logic [2:0] v);
    onehot_idx = v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
  endfunction

  function automatic logic [2:0] inc_ptr(input logic [2:0] p);
    inc_ptr = (p == 3'(NUM_RX - 1)) ? 3'h0 : p + 3'h1;
  endfunction

  // strict less-than keeps the lower index on a tie
  function automatic logic [1:0] pick(input logic [2:0] q, input logic [23:0] pr);
    logic [1:0] best;
    logic       have;
    best = 2'h0;
    have = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (q[i] && (!have || pr[i*8 +: 8] < pr[best*8 +: 8])) begin
        best = 2'(i);
        have = 1'b1;
      end
    end
    pick = best;
  endfunction

  // referee for the scheduler, written apart from pick so a slip there shows up
  function automatic logic is_best(input logic [2:0] q, input logic [23:0] pr,
                                   input logic [1:0] w);
    logic good;
    good = q[w];
    for (int j = 0; j < 3; j++) begin
      if (q[j] && (pr[j*8 +: 8] < pr[w*8 +: 8] ||
                   (pr[j*8 +: 8] == pr[w*8 +: 8] && j < int'(w)))) begin
        good = 1'b0;
      end
    end
    is_best = good;
  endfunction

  // ---------------- apb decode ----------------
  wire        setup     = psel & ~penable;
  wire        acc       = psel & penable & pready;
  wire        wr        = acc & pwrite;
  wire [3:0]  widx      = paddr[5:2];
  wire        in_txw    = paddr[11:6] == cmb_pkg::OFF_TX_WIN[11:6];
  wire        in_rxw    = paddr[11:6] == cmb_pkg::OFF_RX_WIN[11:6];
  wire        hit_reg   = (paddr[11:5] == 7'h00);
  wire        mapped    = in_txw | in_rxw | hit_reg;
  wire        init      = ctrl[cmb_pkg::CTRL_INIT];
  wire        stamp_en  = ctrl[cmb_pkg::CTRL_STAMP];
  wire        loop      = ctrl[cmb_pkg::CTRL_LOOP];
  wire [1:0]  sel_idx   = onehot_idx(tsel);
  wire        sel_free  = |(tsel & empty);
  wire        rx_full_flag       = count != 3'h0;
  wire        full      = count == 3'(NUM_RX);

  wire        wr_txflag = wr & (paddr == cmb_pkg::OFF_TX_FLAG);
  wire        wr_abrq   = wr & (paddr == cmb_pkg::OFF_ABORT_RQ);
  wire        wr_rxflag = wr & (paddr == cmb_pkg::OFF_RX_FLAG);
  wire        wr_txw    = wr & in_txw & sel_free & (widx < cmb_pkg::POS_STAMP_HI);

  // ---------------- transmit scheduling ----------------
  wire [2:0]  cur_oh    = busy ? (3'h1 << cur) : 3'h0;
  wire [2:0]  abort_now = abrq & ~empty & ~cur_oh;
  wire [2:0]  sent      = (eng.tx_ok & busy) ? cur_oh : 3'h0;
  wire [2:0]  queued    = ~empty & ~abort_now;
  wire [23:0] local_priority_field_vec  = {txb[2][cmb_pkg::POS_LOCAL_PRIORITY_FIELD], txb[1][cmb_pkg::POS_LOCAL_PRIORITY_FIELD],
                           txb[0][cmb_pkg::POS_LOCAL_PRIORITY_FIELD]};
  wire [1:0]  best      = pick(queued, local_priority_field_vec);
  wire [2:0]  set_e     = sent | abort_now;
  wire [2:0]  clr_e     = wr_txflag ? pwdata[2:0] : 3'h0;

  // ---------------- receive fifo ----------------
  wire        pop       = wr_rxflag & pwdata[cmb_pkg::RXF_FULL] & rx_full_flag;
  wire        accept    = eng.rx_ok & eng.filter_pass &
                          (~eng.own_frame | loop);
  wire        push      = accept & (~full | pop);
  wire        overrun   = accept & full & ~pop;

  // ---------------- read mux ----------------
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (in_txw) begin
      if (sel_free) begin
        rd_val[7:0] = txb[sel_idx][widx];
      end
    end else if (in_rxw) begin
      if (rx_full_flag && widx != cmb_pkg::POS_LOCAL_PRIORITY_FIELD) begin
        rd_val[7:0] = fifo[rd_ptr][widx];
      end
    end else begin
      unique case (paddr)
        cmb_pkg::OFF_CTRL:      rd_val[2:0]  = ctrl;
        cmb_pkg::OFF_TX_FLAG:   rd_val[2:0]  = empty;
        cmb_pkg::OFF_IRQ_EN:    rd_val[4:0]  = ien;
        cmb_pkg::OFF_ABORT_RQ:  rd_val[2:0]  = abrq;
        cmb_pkg::OFF_ABORT_AK:  rd_val[2:0]  = abak;
        cmb_pkg::OFF_TX_SEL:    rd_val[2:0]  = tsel;
        cmb_pkg::OFF_RX_FLAG:   rd_val[1:0]  = {ovr, rx_full_flag};
        cmb_pkg::OFF_STAMP_CNT: rd_val[15:0] = cnt;
        default:                rd_val       = 32'h0000_0000;
      endcase
    end
  end

  // ---------------- apb handshake ----------------
  // read data is sampled in the setup cycle so prdata is a plain flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
      end
    end
  end

  // ---------------- control registers ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl  <= cmb_pkg::CTRL_RST;
      ien   <= cmb_pkg::IEN_RST;
      tsel  <= 3'h0;
      ovr   <= 1'b0;
    end else begin
      if (wr && paddr == cmb_pkg::OFF_CTRL) begin
        ctrl <= pwdata[2:0];
      end
      if (wr && paddr == cmb_pkg::OFF_IRQ_EN) begin
        ien <= pwdata[4:0];
      end
      if (wr && paddr == cmb_pkg::OFF_TX_SEL) begin
        tsel <= lowest_one(pwdata[2:0] & empty);
      end
      // a new overrun beats a clear in the same cycle
      ovr <= overrun | (ovr & ~(wr_rxflag & pwdata[cmb_pkg::RXF_OVR]));
    end
  end

  // ---------------- slot flags ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty <= cmb_pkg::TX_EMPTY_RST;
      abrq  <= 3'h0;
      abak  <= 3'h0;
    end else begin
      empty <= set_e | (empty & ~clr_e);
      abrq  <= ~set_e & ~empty & (abrq | (wr_abrq ? pwdata[2:0] : 3'h0));
      abak  <= abort_now | (abak & ~sent & ~(clr_e & empty));
    end
  end

  // ---------------- scheduler ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy    <= 1'b0;
      cur     <= 2'h0;
      eng_out <= '0;
    end else begin
      if (eng.tx_pick && !busy) begin
        busy             <= |queued;
        cur              <= best;
        eng_out.tx_valid <= |queued;
        eng_out.tx_idx   <= best;
      end else if (eng.tx_ok || eng.tx_fail || init) begin
        // a failed attempt drops back so the next pick re-runs priority
        busy             <= 1'b0;
        eng_out.tx_valid <= 1'b0;
      end
      eng_out.tx_rd_data <= txb[cur][eng.tx_rd_addr];
      eng_out.ack_allow  <= ~busy | loop;
    end
  end

  // ---------------- stamp counter ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
    end else if (init) begin
      cnt <= 16'h0000;
    end else if (eng.bit_tick) begin
      cnt <= cnt + 16'h0001;
    end
  end

  // ---------------- message memories ----------------
  wire stamp_now = eng.ack_delim & stamp_en;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < NUM_TX; s++) begin
        for (int b = 0; b < cmb_pkg::SLOT_BYTES; b++) begin
          txb[s][b] <= 8'h00;
        end
      end
    end else begin
      if (wr_txw) begin
        txb[sel_idx][widx] <= pwdata[7:0];
      end
      if (stamp_now && busy) begin
        txb[cur][cmb_pkg::POS_STAMP_HI] <= cnt[15:8];
        txb[cur][cmb_pkg::POS_STAMP_LO] <= cnt[7:0];
      end
    end
  end

  // background slot keeps filling even while the fifo is full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < cmb_pkg::SLOT_BYTES; b++) begin
        bg[b] <= 8'h00;
      end
    end else begin
      if (eng.rx_we) begin
        bg[eng.rx_addr] <= eng.rx_data;
      end
      if (stamp_now) begin
        bg[cmb_pkg::POS_STAMP_HI] <= cnt[15:8];
        bg[cmb_pkg::POS_STAMP_LO] <= cnt[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      count  <= 3'h0;
      for (int s = 0; s < NUM_RX; s++) begin
        for (int b = 0; b < cmb_pkg::SLOT_BYTES; b++) begin
          fifo[s][b] <= 8'h00;
        end
      end
    end else begin
      if (push) begin
        for (int b = 0; b < cmb_pkg::SLOT_BYTES; b++) begin
          fifo[wr_ptr][b] <= bg[b];
        end
        wr_ptr <= inc_ptr(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= inc_ptr(rd_ptr);
      end
      count <= count + {2'h0, push} - {2'h0, pop};
    end
  end

  // ---------------- interrupt lines ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_irq  <= 1'b0;
      rx_irq  <= 1'b0;
      ovr_irq <= 1'b0;
    end else begin
      tx_irq  <= |(empty & ien[2:0]);
      rx_irq  <= rx_full_flag & ien[cmb_pkg::IEN_RX];
      ovr_irq <= ovr & ien[cmb_pkg::IEN_OVR];
    end
  end

  // ---------------- assertions ----------------
  sequence s_abort_seen;
    |abort_now;
  endsequence

  sequence s_released(logic [2:0] m);
    ((empty & abak & m) == m) ##1 ((abrq & m) == 3'h0);
  endsequence

  a_cnt_init_zero: assert property (@(posedge pclk) disable iff (!presetn)
    init |=> cnt == 16'h0000)
    else $error("stamp counter not cleared in init mode");

  a_cnt_bit_step: assert property (@(posedge pclk) disable iff (!presetn)
    !init && eng.bit_tick |=> cnt == $past(cnt) + 16'h0001)
    else $error("stamp counter did not step on bit tick");

  a_stamp_rx_cap: assert property (@(posedge pclk) disable iff (!presetn)
    stamp_now && !eng.rx_we |=> {bg[14], bg[15]} == $past(cnt))
    else $error("background stamp differs from counter");

  a_sent_sets_empty: assert property (@(posedge pclk) disable iff (!presetn)
    eng.tx_ok && busy |=> empty[$past(cur)] && !abak[$past(cur)])
    else $error("sent slot not released as sent");

  a_abort_release: assert property (@(posedge pclk) disable iff (!presetn)
    s_abort_seen |=> s_released($past(abort_now)))
    else $error("abort not acknowledged and released");

  a_busy_not_abort: assert property (@(posedge pclk) disable iff (!presetn)
    busy && abrq[cur] && !eng.tx_ok && !init |=> !empty[$past(cur)])
    else $error("slot in transmission was aborted");

  a_pick_queued: assert property (@(posedge pclk) disable iff (!presetn)
    eng.tx_pick && !busy && |queued |=>
      eng_out.tx_valid && is_best($past(queued), $past(local_priority_field_vec), eng_out.tx_idx))
    else $error("picked slot not queued or not best");

  a_rx_push_flag: assert property (@(posedge pclk) disable iff (!presetn)
    accept && !full |=> rx_full_flag && count == $past(count) + 3'h1 - {2'h0, $past(pop)})
    else $error("accepted frame not shifted into fifo");

  a_own_not_queued: assert property (@(posedge pclk) disable iff (!presetn)
    eng.rx_ok && eng.own_frame && !loop && !pop |=> count == $past(count))
    else $error("own frame entered the fifo");

  a_overrun_flag: assert property (@(posedge pclk) disable iff (!presetn)
    overrun |=> ovr && count == 3'(NUM_RX) ##1 ovr_irq == ien[cmb_pkg::IEN_OVR])
    else $error("overrun not flagged or frame not discarded");
endmodule
`default_nettype wire

// >>> tb_cmb_store.sv
// Purpose: self-checking bench for the CAN message buffer store
// Assumes: apb slave answers on its own; the node model makes engine events
// Notes:   the stamp counter is tracked here from the ticks that are sent
`timescale 1ns/1ps
`default_nettype none
module tb_cmb_store;
  localparam logic [11:0] CTL = cmb_pkg::OFF_CTRL;
  localparam logic [11:0] TXF = cmb_pkg::OFF_TX_FLAG;
  localparam logic [11:0] IEN = cmb_pkg::OFF_IRQ_EN;
  localparam logic [11:0] ABQ = cmb_pkg::OFF_ABORT_RQ;
  localparam logic [11:0] ABK = cmb_pkg::OFF_ABORT_AK;
  localparam logic [11:0] SEL = cmb_pkg::OFF_TX_SEL;
  localparam logic [11:0] RX_FULL_FLAG = cmb_pkg::OFF_RX_FLAG;
  localparam logic [11:0] CNT = cmb_pkg::OFF_STAMP_CNT;
  localparam logic [11:0] RXW = cmb_pkg::OFF_RX_WIN;
  localparam logic [11:0] TXW = cmb_pkg::OFF_TX_WIN;
  localparam logic [11:0] TXP = cmb_pkg::OFF_TX_WIN + 12'h034;
  localparam logic [11:0] TXH = cmb_pkg::OFF_TX_WIN + 12'h038;
  localparam logic [11:0] TXL = cmb_pkg::OFF_TX_WIN + 12'h03c;
  logic                  pclk    = 1'b0;
  logic                  presetn;
  logic [11:0]           paddr;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [31:0]           pwdata;
  wire logic [31:0]      prdata;
  wire logic             pready, pslverr, tx_irq, rx_irq, ovr_irq;
  wire cmb_pkg::cmb_eng_in_t  eng;
  wire cmb_pkg::cmb_eng_out_t eng_out;
  logic [31:0]           rd;
  logic                  err;
  logic [15:0]           cnt  = 16'h0000;
  logic [15:0]           stp;
  logic [7:0]            local_priority_field [3] = '{8'h30, 8'h10, 8'h10};
  logic [7:0]            fifo [5] = '{8'h10, 8'h40, 8'h50, 8'h60, 8'h70};
  int                    num_errors  = 0;
  int                    check_count = 0;

  always #50 pclk = ~pclk;

  cmb_store cmb_store_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
                            .prdata, .pready, .pslverr, .eng, .eng_out, .tx_irq, .rx_irq,
                            .ovr_irq);
  cmb_node cmb_node_inst (.pclk, .eng);

  task automatic summarize();
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one idle cycle after each transfer keeps psel from being driven twice at one edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      summarize();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic tk(input int n);
    cmb_node_inst.ticks(n);
    cnt = cnt + 16'(n);
  endtask

  initial begin
    presetn <= 1'b0;
    paddr   <= 12'h000;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    pwdata  <= 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(CTL, 32'h1);
    rdc(TXF, 32'h7);
    rdc(SEL, 32'h0);
    rdc(RX_FULL_FLAG, 32'h0);
    cmb_node_inst.ticks(5);
    rdc(CNT, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    wr(CTL, 32'h2);
    tk(300);
    rdc(CNT, 32'(cnt));
    tk(65536);
    rdc(CNT, 32'(cnt));
    wr(IEN, 32'h1f);
    for (int s = 0; s < 3; s++) begin
      wr(SEL, 32'(1 << s));
      rdc(SEL, 32'(1 << s));
      wr(TXW, 32'(8'ha0 + s));
      wr(TXP, 32'(local_priority_field[s]));
      rdc(TXW, 32'(8'ha0 + s));
      rdc(TXP, 32'(local_priority_field[s]));
    end
    wr(TXF, 32'h7);
    rdc(TXF, 32'h0);
    chk(32'(tx_irq), 32'h0);
    wr(SEL, 32'h7);
    rdc(SEL, 32'h0);
    rdc(TXP, 32'h0);
    cmb_node_inst.ev(5'h08);
    // ack_allow and the fetched byte follow busy and cur one edge later
    @(posedge pclk);
    chk(32'({eng_out.tx_valid, eng_out.tx_idx}), 32'h5);
    chk(32'({eng_out.ack_allow, eng_out.tx_rd_data}), 32'h0a1);
    cmb_node_inst.rd_at(cmb_pkg::POS_LOCAL_PRIORITY_FIELD);
    chk(32'(eng_out.tx_rd_data), 32'(local_priority_field[1]));
    cmb_node_inst.ev(5'h02);
    cmb_node_inst.rx_frame(8'h10, 1'b1, 1'b0);
    cmb_node_inst.ev(5'h08);
    chk(32'({eng_out.tx_valid, eng_out.tx_idx}), 32'h5);
    tk(7);
    stp = cnt;
    cmb_node_inst.ev(5'h01);
    tk(3);
    cmb_node_inst.ev(5'h04);
    rdc(TXF, 32'h2);
    chk(32'(tx_irq), 32'h1);
    wr(ABQ, 32'h1);
    rdc(ABK, 32'h1);
    rdc(TXF, 32'h3);
    cmb_node_inst.ev(5'h08);
    chk(32'({eng_out.tx_valid, eng_out.tx_idx}), 32'h6);
    wr(ABQ, 32'h4);
    rdc(TXF, 32'h3);
    cmb_node_inst.ev(5'h04);
    rdc(ABK, 32'h1);
    wr(IEN, 32'h18);
    rdc(TXF, 32'h7);
    chk(32'(tx_irq), 32'h0);
    wr(SEL, 32'h2);
    wr(TXL, 32'hff);
    rdc(TXH, 32'(stp[15:8]));
    rdc(TXL, 32'(stp[7:0]));
    rdc(RX_FULL_FLAG, 32'h1);
    chk(32'(rx_irq), 32'h1);
    rdc(RXW + 12'h030, 32'h1c);
    cmb_node_inst.rx_frame(8'h20, 1'b0, 1'b0);
    cmb_node_inst.rx_frame(8'h30, 1'b1, 1'b1);
    wr(CTL, 32'h6);
    for (int i = 1; i < 5; i++) begin
      cmb_node_inst.rx_frame(fifo[i], 1'b1, 1'b1);
    end
    cmb_node_inst.rx_frame(8'h80, 1'b1, 1'b0);
    rdc(RX_FULL_FLAG, 32'h3);
    chk(32'(ovr_irq), 32'h1);
    wr(RX_FULL_FLAG, 32'h2);
    rdc(RX_FULL_FLAG, 32'h1);
    for (int i = 0; i < 5; i++) begin
      rdc(RXW, 32'(fifo[i]));
      wr(RX_FULL_FLAG, 32'h1);
    end
    rdc(RX_FULL_FLAG, 32'h0);
    chk(32'(rx_irq), 32'h0);
    cmb_node_inst.rx_frame(8'h90, 1'b1, 1'b0);
    rdc(RXW, 32'h90);
    rdc(RXW + 12'h03c, 32'(cnt[7:0]));
    wr(CTL, 32'h1);
    rdc(CNT, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
